// [dv/hss_ctl_model.sv]
// Machine controller model: drives the block's control pins from requested levels.
// Assumes requests come from the bench; slow adds one cycle of lag like a slow PLC.
`timescale 1ns/10ps
`default_nettype none
module hss_ctl_model (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic slow,
    input wire logic [hss_pkg::NPIN-1:0] want,
    output var logic [hss_pkg::NPIN-1:0] pins
);
    import hss_pkg::*;
    logic [NPIN-1:0] stage;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stage <= '0;
            pins <= '0;
        end else begin
            stage <= want;
            pins <= slow ? stage : want;
        end
    end
endmodule : hss_ctl_model
`default_nettype wire

// [dv/hss_supervisor_monitor.sv]
// Port-level checks of the heat-seal supervisory block, bound into each instance.
// Assumes one clock domain and the design's asynchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module hss_supervisor_monitor (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire hss_pkg::hss_bus_t bus,
    input wire logic [31:0] rdata,
    input wire hss_pkg::hss_meas_t meas,
    input wire logic heat_enable,
    input wire logic [hss_pkg::TEMP_W-1:0] heat_setpoint,
    input wire logic alarm_relay,
    input wire logic in_tolerance,
    input wire logic [hss_pkg::TEMP_W-1:0] actual_out,
    input wire logic [hss_pkg::TEMP_W-1:0] bar_value,
    input wire logic [1:0] brightness,
    input wire logic standby,
    input wire logic measure_enable,
    input wire logic timeout_active
);
    import hss_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    // ----
    // Checks
    // ----
    AST_BAR_LIVE: assert property (
        $past(reset_n) && $past(clk_en) |-> bar_value == $past(meas.temp))
        else $error("bar value does not follow the live temperature");
    AST_STBY_ZERO: assert property (
        standby |-> actual_out == '0)
        else $error("actual output not zero in standby");
    AST_STBY_HALT: assert property (
        standby |-> !heat_enable && !timeout_active && !measure_enable)
        else $error("heating or measurement active in standby");
    AST_STBY_RELAY: assert property (
        standby |-> !alarm_relay)
        else $error("alarm relay switched in standby");
    AST_ALARM_TOL: assert property (
        meas.alarm_valid [*3] |-> !in_tolerance)
        else $error("in-tolerance output on during an alarm");
    AST_ALARM_NOHEAT: assert property (
        alarm_relay |-> !heat_enable)
        else $error("band heated while the alarm relay is on");
    AST_HEAT_MIN: assert property (
        heat_enable |-> heat_setpoint > MIN_HEAT_SP)
        else $error("band heated toward a setpoint of 40 or less");
    AST_CAL_BLOCK: assert property (
        meas.calib_running [*8] |-> !$rose(timeout_active))
        else $error("timed cycle launched during calibration");
    AST_BRIGHT_STEP: assert property (
        $changed(brightness) |-> brightness == $past(brightness) + 2'h1
            || brightness == $past(brightness) - 2'h1)
        else $error("brightness jumped by more than one level");
    AST_RD_IDLE: assert property (
        !$past(bus.rd) |-> rdata == '0)
        else $error("read data present without a read");
endmodule : hss_supervisor_monitor
bind hss_supervisor hss_supervisor_monitor u_mon (
    .clk(clk), .reset_n(reset_n), .clk_en(clk_en), .bus(bus), .rdata(rdata), .meas(meas),
    .heat_enable(heat_enable), .heat_setpoint(heat_setpoint), .alarm_relay(alarm_relay),
    .in_tolerance(in_tolerance), .actual_out(actual_out), .bar_value(bar_value),
    .brightness(brightness), .standby(standby), .measure_enable(measure_enable),
    .timeout_active(timeout_active));
`default_nettype wire

// [dv/test_hss_supervisor.sv]
// Self-checking bench of the heat-seal supervisory block.
// Assumes package, design, monitor and controller model are compiled before it.
`timescale 1ns/10ps
`default_nettype none
module test_hss_supervisor;
    import hss_pkg::*;
    localparam int HOLD_N = 200;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic lock_saved = 1'b0;
    logic slow = 1'b0;
    logic clk_en = 1'b1;
    hss_bus_t bus = '0;
    hss_meas_t meas = '0;
    logic [NPIN-1:0] want = '0;
    logic [NPIN-1:0] pins;
    logic [31:0] rdata;
    logic heat_enable, alarm_relay, in_tolerance, auxiliary_relay, hold_indicator, standby;
    logic measure_enable, timeout_active, config_lock, lock_message, lock_notice;
    logic [TEMP_W-1:0] heat_setpoint, actual_out, bar_value, display_value;
    logic [1:0] brightness;
    int n_fail = 0;
    int n_tests = 0;
    int cnt = 0;
    logic [11:0] codes [7] = '{12'h068, 12'h069, 12'h06F, 12'h070, 12'h071, 12'h0D3, 12'h06A};
    logic [9:0] tv [4] = '{10'h072, 10'h073, 10'h07B, 10'h07C};
    int bk [6] = '{P_UP, P_UP, P_DOWN, P_DOWN, P_DOWN, P_DOWN};
    logic [1:0] be [6] = '{2'h3, 2'h3, 2'h2, 2'h1, 2'h0, 2'h0};
    always #25 clk = ~clk;
    hss_supervisor #(.HOLD_CYCLES(HOLD_N), .BLANK_CYCLES(20), .LOCK_PRESS_CYCLES(50),
        .LOCK_MSG_CYCLES(60), .NOTICE_CYCLES(100), .POWERUP_CYCLES(300)) dut (
        .clk(clk), .reset_n(reset_n), .clk_en(clk_en), .bus(bus), .rdata(rdata), .pins(pins),
        .meas(meas), .lock_saved(lock_saved), .heat_enable(heat_enable),
        .heat_setpoint(heat_setpoint), .alarm_relay(alarm_relay), .in_tolerance(in_tolerance),
        .auxiliary_relay(auxiliary_relay), .actual_out(actual_out), .bar_value(bar_value),
        .display_value(display_value), .hold_indicator(hold_indicator),
        .brightness(brightness), .standby(standby), .measure_enable(measure_enable),
        .timeout_active(timeout_active), .config_lock(config_lock),
        .lock_message(lock_message), .lock_notice(lock_notice));
    hss_ctl_model ctl (.clk(clk), .reset_n(reset_n), .slow(slow), .want(want), .pins(pins));
    task summarize;
        $display("checks=%0d mismatches=%0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    task wr(input logic [7:0] a, input logic [31:0] d);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus <= '0;
        @(posedge clk);
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] exp);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus <= '0;
        #1;
        chk(rdata, exp);
        @(posedge clk);
    endtask : rd
    task pin(input int p, input logic v);
        want[p] <= v;
        step(10);
    endtask : pin
    task do_reset;
        reset_n <= 1'b0;
        step(3);
        reset_n <= 1'b1;
        step(2);
    endtask : do_reset
    initial begin
        #5000000;
        n_fail++;
        summarize();
    end
    initial begin
        do_reset();
        meas.home_view <= 1'b1;
        rd(REG_SETPOINT, 32'h78);
        rd(REG_TOL_LOW, 32'hA);
        rd(REG_STATUS, 32'h200);
        rd(8'h20, 32'h0);
        $display("reset values done");
        wr(REG_WARM_SP, 32'h28);
        pin(P_WARM, 1'b1);
        chk(heat_enable, 1'b0);
        wr(REG_WARM_SP, 32'h29);
        step(3);
        chk(heat_enable, 1'b1);
        chk(heat_setpoint, 10'h029);
        pin(P_START, 1'b1);
        chk(heat_setpoint, SETPOINT_RST);
        pin(P_START, 1'b0);
        cnt++;
        pin(P_WARM, 1'b0);
        pin(P_MANUAL, 1'b1);
        chk(heat_enable, 1'b1);
        pin(P_MANUAL, 1'b0);
        rd(REG_COUNT, cnt);
        meas.calib_running <= 1'b1;
        pin(P_START, 1'b1);
        chk(heat_enable, 1'b0);
        pin(P_START, 1'b0);
        meas.calib_running <= 1'b0;
        rd(REG_COUNT, cnt);
        $display("warm hold and start done");
        for (int i = 0; i < 7; i++) begin
            meas.alarm_code <= codes[i];
            meas.alarm_valid <= 1'b1;
            pin(P_WARM, 1'b1);
            chk(alarm_relay, i < 6);
            chk(heat_enable, i == 6);
            chk(in_tolerance, 1'b0);
            pin(P_WARM, 1'b0);
            meas.alarm_valid <= 1'b0;
            step(3);
        end
        $display("alarm codes done");
        wr(REG_CTRL, 32'h8);
        wr(REG_TOL_LOW, 32'h5);
        wr(REG_TOL_HIGH, 32'h3);
        for (int i = 0; i < 4; i++) begin
            meas.temp <= tv[i];
            step(4);
            chk(in_tolerance, i == 1 || i == 2);
            chk(auxiliary_relay, i == 1 || i == 2);
        end
        meas.counter_view <= 1'b1;
        pin(P_CONFIRM, 1'b1);
        pin(P_CONFIRM, 1'b0);
        meas.counter_view <= 1'b0;
        cnt = 0;
        rd(REG_COUNT, cnt);
        $display("window and counter done");
        wr(REG_CTRL, 32'h2);
        meas.temp <= 10'h046;
        pin(P_START, 1'b1);
        pin(P_START, 1'b0);
        cnt++;
        meas.temp <= 10'h05A;
        step(4);
        chk(display_value, 10'h046);
        chk(bar_value, 10'h05A);
        chk(actual_out, 10'h05A);
        chk(hold_indicator, 1'b0);
        step(20);
        chk(hold_indicator, 1'b1);
        wr(REG_CTRL, 32'h4);
        pin(P_START, 1'b1);
        pin(P_START, 1'b0);
        cnt++;
        meas.temp <= 10'h05F;
        step(4);
        chk(display_value, 10'h05A);
        step(HOLD_N);
        chk(display_value, 10'h05F);
        wr(REG_CTRL, 32'h0);
        meas.temp <= 10'h064;
        step(4);
        chk(display_value, 10'h064);
        $display("hold modes done");
        slow <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            pin(bk[i], 1'b1);
            pin(bk[i], 1'b0);
            chk(brightness, be[i]);
        end
        slow <= 1'b0;
        pin(P_START, 1'b1);
        cnt++;
        pin(P_UNDERV, 1'b1);
        chk(standby, 1'b1);
        chk(heat_enable, 1'b0);
        chk(measure_enable, 1'b0);
        chk(actual_out, 10'h000);
        pin(P_UNDERV, 1'b0);
        chk(standby, 1'b0);
        chk(actual_out, 10'h064);
        pin(P_START, 1'b0);
        $display("brightness and standby done");
        wr(REG_CTRL, 32'h1);
        pin(P_START, 1'b1);
        pin(P_START, 1'b0);
        cnt++;
        chk(timeout_active, 1'b1);
        meas.cooling_done <= 1'b1;
        step(1);
        meas.cooling_done <= 1'b0;
        step(3);
        chk(timeout_active, 1'b0);
        pin(P_START, 1'b1);
        pin(P_START, 1'b0);
        cnt++;
        chk(timeout_active, 1'b1);
        pin(P_RESET, 1'b1);
        chk(timeout_active, 1'b0);
        pin(P_RESET, 1'b0);
        rd(REG_COUNT, cnt);
        $display("timed cycle done");
        do_reset();
        pin(P_MENU, 1'b1);
        step(60);
        pin(P_MENU, 1'b0);
        chk(config_lock, 1'b1);
        chk(lock_message, 1'b1);
        step(60);
        chk(lock_message, 1'b0);
        wr(REG_SETPOINT, 32'h64);
        rd(REG_SETPOINT, 32'h78);
        meas.config_open <= 1'b1;
        step(1);
        meas.config_open <= 1'b0;
        step(3);
        chk(lock_notice, 1'b1);
        lock_saved <= 1'b1;
        do_reset();
        chk(config_lock, 1'b1);
        $display("configuration lock done");
        clk_en <= 1'b0;
        meas.temp <= 10'h011;
        step(4);
        chk(bar_value, 10'h064);
        clk_en <= 1'b1;
        step(3);
        chk(bar_value, 10'h011);
        $display("clock enable done");
        summarize();
    end
endmodule : test_hss_supervisor
`default_nettype wire

// [src/hss_pkg.sv]
// Shared constants and carrier types of the heat-seal supervisory block.
// Assumes a single 20 MHz clock; time figures are converted to cycle counts here.
package hss_pkg;
    localparam int CLK_HZ = 20000000;
    localparam int TEMP_W = 10;
    localparam int CNT_W = 30;
    // ----
    // Register map and field positions
    // ----
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_SETPOINT = 8'h04;
    localparam logic [7:0] REG_WARM_SP = 8'h08;
    localparam logic [7:0] REG_TOL_LOW = 8'h0C;
    localparam logic [7:0] REG_TOL_HIGH = 8'h10;
    localparam logic [7:0] REG_STATUS = 8'h14;
    localparam logic [7:0] REG_COUNT = 8'h18;
    localparam logic [7:0] REG_DISPLAY = 8'h1C;
    localparam int CTRL_TIMED = 0;
    localparam int CTRL_HOLD = 1;
    localparam int CTRL_AUX = 3;
    // ----
    // Reset values and limits
    // ----
    localparam logic [TEMP_W-1:0] MIN_HEAT_SP = 10'h028;
    localparam logic [TEMP_W-1:0] SETPOINT_RST = 10'h078;
    localparam logic [TEMP_W-1:0] WARM_SP_RST = 10'h000;
    localparam logic [TEMP_W-1:0] TOL_RST = 10'h00A;
    localparam logic [CNT_W-1:0] COUNT_MAX = 30'h3B9AC9FF;
    localparam logic [1:0] BRIGHT_RST = 2'h2;
    localparam logic [1:0] BRIGHT_MAX = 2'h3;
    // ----
    // Hold modes and pin indices of the synchronised inputs
    // ----
    typedef enum logic [1:0] {
        HSS_HOLD_OFF = 2'h0,
        HSS_HOLD_ON = 2'h1,
        HSS_HOLD_TIMED = 2'h2
    } hss_hold_t;
    localparam int NPIN = 9;
    localparam int P_START = 0;
    localparam int P_WARM = 1;
    localparam int P_RESET = 2;
    localparam int P_MANUAL = 3;
    localparam int P_MENU = 4;
    localparam int P_UP = 5;
    localparam int P_DOWN = 6;
    localparam int P_CONFIRM = 7;
    localparam int P_UNDERV = 8;
    // ----
    // Timing
    // ----
    localparam int HOLD_MS = 2000;
    localparam int BLANK_MS = 100;
    localparam int LOCK_PRESS_MS = 2000;
    localparam int LOCK_MSG_MS = 3000;
    localparam int NOTICE_MS = 5000;
    localparam int POWERUP_MS = 4000;
    localparam int HOLD_CYC = HOLD_MS * (CLK_HZ / 1000);
    localparam int BLANK_CYC = BLANK_MS * (CLK_HZ / 1000);
    localparam int LOCK_PRESS_CYC = LOCK_PRESS_MS * (CLK_HZ / 1000);
    localparam int LOCK_MSG_CYC = LOCK_MSG_MS * (CLK_HZ / 1000);
    localparam int NOTICE_CYC = NOTICE_MS * (CLK_HZ / 1000);
    localparam int POWERUP_CYC = POWERUP_MS * (CLK_HZ / 1000);
    // ----
    // Carriers
    // ----
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } hss_bus_t;
    typedef struct packed {
        logic [TEMP_W-1:0] temp;
        logic [11:0] alarm_code;
        logic alarm_valid;
        logic calib_running;
        logic home_view;
        logic counter_view;
        logic config_open;
        logic cooling_done;
    } hss_meas_t;
endpackage : hss_pkg

// [src/hss_supervisor.sv]
// Supervisory sequencing of a heat-sealing band controller: warm-hold gating,
// tolerance window, cycle counter, display hold, configuration lock, brightness,
// undervoltage standby and the timed-cycle timeout.
// Assumes one clock, pins arriving asynchronously, and measurement, alarm and
// menu information coming from logic on the same clock.
//
// Overview of operation
// RULE_01: warm-hold request regulates to warm-hold setpoint
// RULE_02: no warm-hold heating unless setpoint exceeds 40
// RULE_03: listed alarm plus request: relay on, no heat
// RULE_04: main heat cycle masks warm-hold request
// RULE_05: cycle-start ignored during zero calibration
// RULE_06: in-tolerance inside independently set window
// RULE_07: in-tolerance forced off while alarm signalled
// RULE_08: auxiliary relay follows tolerance when untimed
// RULE_09: count cycle-start activations, never manual heat
// RULE_10: counter clears on confirm or overflow
// RULE_11: hold off shows live temperature
// RULE_12: hold on shows value latched at phase end
// RULE_13: hold on shows live until first capture
// RULE_14: timed hold shows capture for 2 s
// RULE_15: bar and actual output always live; the code forces actual output to zero in standby
// RULE_16: hold indicator blanks 100 ms on refresh
// RULE_17: menu held 2 s at power-up toggles lock
// RULE_18: locked menu shows notice 5 s, rejects edits
// RULE_19: lock off by default, persists externally
// RULE_20: up/down step brightness, 75% default
// RULE_21: undervoltage standby stops cycles and measurement
// RULE_22: standby leaves alarm relay, actual output zero
// RULE_23: timed start launches timeout until cooling or reset
// RULE_24: untimed start regulates while input held
// RULE_25: window boundaries count as inside
//
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module hss_supervisor #(
    parameter int HOLD_CYCLES = hss_pkg::HOLD_CYC,
    parameter int BLANK_CYCLES = hss_pkg::BLANK_CYC,
    parameter int LOCK_PRESS_CYCLES = hss_pkg::LOCK_PRESS_CYC,
    parameter int LOCK_MSG_CYCLES = hss_pkg::LOCK_MSG_CYC,
    parameter int NOTICE_CYCLES = hss_pkg::NOTICE_CYC,
    parameter int POWERUP_CYCLES = hss_pkg::POWERUP_CYC
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire hss_pkg::hss_bus_t bus,
    output logic [31:0] rdata,
    input wire logic [hss_pkg::NPIN-1:0] pins,
    input wire hss_pkg::hss_meas_t meas,
    input wire logic lock_saved,
    output logic heat_enable,
    output logic [hss_pkg::TEMP_W-1:0] heat_setpoint,
    output logic alarm_relay,
    output logic in_tolerance,
    output logic auxiliary_relay,
    output logic [hss_pkg::TEMP_W-1:0] actual_out,
    output logic [hss_pkg::TEMP_W-1:0] bar_value,
    output logic [hss_pkg::TEMP_W-1:0] display_value,
    output logic hold_indicator,
    output logic [1:0] brightness,
    output logic standby,
    output logic measure_enable,
    output logic timeout_active,
    output logic config_lock,
    output logic lock_message,
    output logic lock_notice
);
    import hss_pkg::*;

    typedef struct packed {
        logic [NPIN-1:0] s1;
        logic [NPIN-1:0] s2;
        logic [NPIN-1:0] s3;
        logic [NPIN-1:0] filt;
        logic [NPIN-1:0] prev;
        logic timed_en;
        logic [1:0] hold_mode;
        logic aux_follow;
        logic [TEMP_W-1:0] setpoint;
        logic [TEMP_W-1:0] warm_sp;
        logic [TEMP_W-1:0] tol_lo;
        logic [TEMP_W-1:0] tol_hi;
        logic main_prev;
        logic timeout_active;
        logic relay_latch;
        logic [CNT_W-1:0] count;
        logic [TEMP_W-1:0] held_temp;
        logic held_valid;
        logic [31:0] hold_cnt;
        logic [31:0] blank_cnt;
        logic [31:0] pwr_cnt;
        logic [31:0] menu_cnt;
        logic [31:0] msg_cnt;
        logic [31:0] notice_cnt;
        logic lock;
        logic lock_loaded;
        logic lock_done;
        logic [1:0] bright;
        logic heat_enable;
        logic [TEMP_W-1:0] heat_sp;
        logic alarm_relay;
        logic in_tol;
        logic aux_relay;
        logic [TEMP_W-1:0] actual_out;
        logic [TEMP_W-1:0] bar_value;
        logic [TEMP_W-1:0] disp_value;
        logic hold_ind;
        logic standby;
        logic [31:0] rdata;
    } hss_state_t;

    // ----
    // Helpers
    // ----
    // Alarm codes during which a heat request is refused and the relay pulled.
    function automatic logic hss_alarm_blocks(input logic [11:0] code);
        logic hit;
        hit = (code >= 12'h068 && code <= 12'h069)
            || (code >= 12'h06F && code <= 12'h071)
            || (code == 12'h0D3);
        return hit;
    endfunction : hss_alarm_blocks

    function automatic logic [31:0] hss_dec(input logic [31:0] v);
        return (v == 32'h0) ? 32'h0 : v - 32'h1;
    endfunction : hss_dec

    hss_state_t st;
    hss_state_t next_st;
    logic [NPIN-1:0] settled;
    logic [NPIN-1:0] rise;
    logic [NPIN-1:0] fall;

    // A pin counts as changed only once stages two and three agree.
    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_pin
            assign settled[gi] = (st.s2[gi] == st.s3[gi]) ? st.s3[gi] : st.filt[gi];
            assign rise[gi] = st.filt[gi] & ~st.prev[gi];
            assign fall[gi] = ~st.filt[gi] & st.prev[gi];
        end
    endgenerate

    // ----
    // Next-state logic
    // ----
    always_comb begin
        logic uv;
        logic start_ok;
        logic main_cycle;
        logic blocked;
        logic warm_eff;
        logic in_win;
        logic showing_held;
        logic capture;
        logic [TEMP_W:0] lo_lim;
        logic [TEMP_W:0] hi_lim;
        logic [TEMP_W:0] t_ext;
        logic [31:0] rd_word;
        uv = st.filt[P_UNDERV];
        start_ok = st.filt[P_START] & ~meas.calib_running; // RULE_05
        blocked = meas.alarm_valid & hss_alarm_blocks(meas.alarm_code);
        next_st = st;
        next_st.s1 = pins;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        next_st.filt = settled;
        next_st.prev = st.filt;

        // Timed cycle: the timeout runs from the start edge to end of cooling.
        if (uv || rise[P_RESET] || meas.cooling_done || !st.timed_en) begin
            next_st.timeout_active = 1'b0; // RULE_23
        end else if (rise[P_START] && !meas.calib_running) begin
            next_st.timeout_active = 1'b1; // RULE_23
        end
        if (st.timed_en) begin
            main_cycle = st.timeout_active | st.filt[P_MANUAL];
        end else begin
            main_cycle = start_ok | st.filt[P_MANUAL]; // RULE_24
        end
        main_cycle = main_cycle & ~uv; // RULE_21
        warm_eff = st.filt[P_WARM] & ~main_cycle & ~uv; // RULE_04
        next_st.main_prev = main_cycle;

        // Heater drive.
        next_st.heat_enable = 1'b0;
        next_st.heat_sp = st.setpoint;
        if (!blocked && main_cycle && st.setpoint > MIN_HEAT_SP) begin
            next_st.heat_enable = 1'b1;
        end else if (!blocked && warm_eff && st.warm_sp > MIN_HEAT_SP) begin // RULE_02
            next_st.heat_enable = 1'b1; // RULE_01
            next_st.heat_sp = st.warm_sp;
        end

        // Alarm relay: a request during a listed alarm latches until it clears.
        if (!meas.alarm_valid) begin
            next_st.relay_latch = 1'b0;
        end else if (blocked && (rise[P_WARM] || rise[P_START])) begin
            next_st.relay_latch = 1'b1; // RULE_03
        end
        next_st.alarm_relay = ~uv & next_st.relay_latch; // RULE_22

        // Tolerance window, boundaries inclusive, limits clipped at zero.
        t_ext = {1'b0, meas.temp};
        lo_lim = (st.tol_lo > st.setpoint) ? '0 : {1'b0, st.setpoint - st.tol_lo};
        hi_lim = {1'b0, st.setpoint} + {1'b0, st.tol_hi};
        in_win = (t_ext >= lo_lim) && (t_ext <= hi_lim); // RULE_25
        next_st.in_tol = in_win & ~meas.alarm_valid; // RULE_06 RULE_07
        next_st.aux_relay = ~st.timed_en & st.aux_follow & next_st.in_tol; // RULE_08

        // Cycle counter.
        if (meas.counter_view && rise[P_CONFIRM]) begin
            next_st.count = '0; // RULE_10
        end else if (rise[P_START] && !meas.calib_running && !uv) begin
            next_st.count = (st.count == COUNT_MAX) ? '0 : st.count + 1'b1; // RULE_09 RULE_10
        end

        // Hold capture at the end of each heating phase.
        capture = st.main_prev & ~main_cycle;
        next_st.hold_cnt = hss_dec(st.hold_cnt);
        next_st.blank_cnt = hss_dec(st.blank_cnt);
        if (capture) begin
            next_st.held_temp = meas.temp; // RULE_12
            next_st.held_valid = 1'b1; // RULE_13
            next_st.hold_cnt = HOLD_CYCLES; // RULE_14
            next_st.blank_cnt = BLANK_CYCLES; // RULE_16
        end
        case (hss_hold_t'(st.hold_mode))
            HSS_HOLD_OFF: showing_held = 1'b0; // RULE_11
            HSS_HOLD_ON: showing_held = st.held_valid; // RULE_12 RULE_13
            HSS_HOLD_TIMED: showing_held = st.held_valid && st.hold_cnt != 32'h0; // RULE_14
            default: showing_held = 1'b0;
        endcase
        next_st.disp_value = showing_held ? st.held_temp : meas.temp;
        next_st.hold_ind = showing_held && st.blank_cnt == 32'h0; // RULE_16
        next_st.bar_value = meas.temp; // RULE_15
        next_st.actual_out = uv ? '0 : meas.temp; // RULE_15 RULE_22
        next_st.standby = uv; // RULE_21

        // Configuration lock: restored once after reset, toggled at power-up.
        next_st.lock_loaded = 1'b1;
        if (!st.lock_loaded) begin
            next_st.lock = lock_saved; // RULE_19
        end
        next_st.pwr_cnt = hss_dec(st.pwr_cnt);
        next_st.msg_cnt = hss_dec(st.msg_cnt);
        next_st.notice_cnt = hss_dec(st.notice_cnt);
        if (st.pwr_cnt != 32'h0 && st.filt[P_MENU] && !st.lock_done) begin
            next_st.menu_cnt = st.menu_cnt + 32'h1;
            if (st.menu_cnt + 32'h1 >= LOCK_PRESS_CYCLES) begin
                next_st.lock = ~st.lock; // RULE_17
                next_st.lock_done = 1'b1;
                next_st.msg_cnt = LOCK_MSG_CYCLES; // RULE_17
            end
        end else begin
            next_st.menu_cnt = 32'h0;
        end
        if (meas.config_open && st.lock) begin
            next_st.notice_cnt = NOTICE_CYCLES; // RULE_18
        end

        // Brightness steps in the home view.
        if (meas.home_view && rise[P_UP] && st.bright != BRIGHT_MAX) begin
            next_st.bright = st.bright + 2'h1; // RULE_20
        end else if (meas.home_view && rise[P_DOWN] && st.bright != 2'h0) begin
            next_st.bright = st.bright - 2'h1; // RULE_20
        end

        // Register writes; configuration edits are refused while locked.
        if (bus.wr && !st.lock) begin // RULE_18
            case (bus.addr)
                REG_CTRL: begin
                    next_st.timed_en = bus.wdata[CTRL_TIMED];
                    next_st.hold_mode = bus.wdata[CTRL_HOLD +: 2];
                    next_st.aux_follow = bus.wdata[CTRL_AUX];
                end
                REG_SETPOINT: next_st.setpoint = bus.wdata[TEMP_W-1:0];
                REG_WARM_SP: next_st.warm_sp = bus.wdata[TEMP_W-1:0];
                REG_TOL_LOW: next_st.tol_lo = bus.wdata[TEMP_W-1:0];
                REG_TOL_HIGH: next_st.tol_hi = bus.wdata[TEMP_W-1:0];
                default: ;
            endcase
        end
        rd_word = 32'h0;
        case (bus.addr)
            REG_CTRL: rd_word = {28'h0, st.aux_follow, st.hold_mode, st.timed_en};
            REG_SETPOINT: rd_word = {22'h0, st.setpoint};
            REG_WARM_SP: rd_word = {22'h0, st.warm_sp};
            REG_TOL_LOW: rd_word = {22'h0, st.tol_lo};
            REG_TOL_HIGH: rd_word = {22'h0, st.tol_hi};
            REG_STATUS: rd_word = {22'h0, st.bright, st.lock, st.standby, st.timeout_active,
                st.hold_ind, st.aux_relay, st.in_tol, st.alarm_relay, st.heat_enable};
            REG_COUNT: rd_word = {2'h0, st.count};
            REG_DISPLAY: rd_word = {22'h0, st.disp_value};
            default: rd_word = 32'h0;
        endcase
        next_st.rdata = bus.rd ? rd_word : 32'h0;
    end

    // ----
    // State register
    // ----
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
            st.setpoint <= SETPOINT_RST;
            st.warm_sp <= WARM_SP_RST;
            st.tol_lo <= TOL_RST;
            st.tol_hi <= TOL_RST;
            st.bright <= BRIGHT_RST; // RULE_20
            st.pwr_cnt <= POWERUP_CYCLES;
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    assign rdata = st.rdata;
    assign heat_enable = st.heat_enable;
    assign heat_setpoint = st.heat_sp;
    assign alarm_relay = st.alarm_relay;
    assign in_tolerance = st.in_tol;
    assign auxiliary_relay = st.aux_relay;
    assign actual_out = st.actual_out;
    assign bar_value = st.bar_value;
    assign display_value = st.disp_value;
    assign hold_indicator = st.hold_ind;
    assign brightness = st.bright;
    assign standby = st.standby;
    assign measure_enable = ~st.standby; // RULE_21
    assign timeout_active = st.timeout_active;
    assign config_lock = st.lock;
    assign lock_message = st.msg_cnt != 32'h0;
    assign lock_notice = st.notice_cnt != 32'h0;
endmodule : hss_supervisor
`default_nettype wire
